// ---- design/delay_timer_pkg.sv ----
// shared constants for the multi mode delay timer
package delay_timer_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // pulse generator output pulse width, in milliseconds
  localparam int unsigned PULSE_MS = 500;
  localparam int unsigned PULSE_CYC = PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 32;
  localparam logic [31:0] DELAY_DEFAULT = 32'h0000_0064;
  typedef enum logic [1:0] {
    MODE_PULSE_GEN = 2'b00,
    MODE_ONE_SHOT = 2'b01,
    MODE_ON_OFF = 2'b10,
    MODE_LATCH = 2'b11
  } mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_DONE = 2'b11
  } state_t;
endpackage : delay_timer_pkg

// ---- design/multi_mode_delay_timer.sv ----
// multi mode delay timer: one load output from power valid and a control input
module multi_mode_delay_timer #(
  parameter logic [31:0] PULSE_CYCLES = 32'(delay_timer_pkg::PULSE_CYC)
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_power_valid,
  input wire logic i_control_input,
  input wire delay_timer_pkg::mode_t i_mode,
  input wire logic [31:0] i_delay_span,
  output logic o_load_switch
);
  import delay_timer_pkg::*;

  logic ctl_meta_r;
  logic ctl_sync_r;
  logic ctl_prev_r;
  logic closure;
  logic pv_prev_r;
  logic pv_rise;
  state_t state_r;
  logic [31:0] count_r;
  logic [31:0] span_m1;

  // two-stage synchroniser then edge detect, so one closure is one event
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctl_meta_r <= 1'b0;
      ctl_sync_r <= 1'b0;
      ctl_prev_r <= 1'b0;
    end
    else
    begin
      ctl_meta_r <= i_control_input;
      ctl_sync_r <= ctl_meta_r;
      ctl_prev_r <= ctl_sync_r;
    end
  end

  assign closure = ctl_sync_r && !ctl_prev_r;

  // power valid edge; power valid is taken as synchronous
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pv_prev_r <= 1'b0;
    else
      pv_prev_r <= i_power_valid;
  end

  assign pv_rise = i_power_valid && !pv_prev_r;
  // a zero span still takes one cycle of timing
  assign span_m1 = (i_delay_span == 32'h0000_0000) ? 32'h0000_0000 : i_delay_span - 32'h1;

  // mode sequencer; power loss overrides everything and returns to rest
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= ST_IDLE;
      count_r <= 32'h0;
      o_load_switch <= 1'b0;
    end
    else if (!i_power_valid)
    begin
      state_r <= ST_IDLE;
      count_r <= 32'h0;
      o_load_switch <= 1'b0;
    end
    else
    begin
      case (i_mode)
        MODE_PULSE_GEN:
        begin
          // control input never read here
          case (state_r)
            ST_IDLE:
            begin
              if (pv_rise)
              begin
                state_r <= ST_DELAY;
                count_r <= span_m1;
              end
            end
            ST_DELAY:
            begin
              if (count_r == 32'h0)
              begin
                state_r <= ST_ACTIVE;
                count_r <= PULSE_CYCLES - 32'h1;
                o_load_switch <= 1'b1;
              end
              else
                count_r <= count_r - 32'h1;
            end
            ST_ACTIVE:
            begin
              if (count_r == 32'h0)
              begin
                state_r <= ST_DONE;
                o_load_switch <= 1'b0;
              end
              else
                count_r <= count_r - 32'h1;
            end
            default:
              o_load_switch <= 1'b0;
          endcase
        end
        MODE_ONE_SHOT:
        begin
          if (state_r == ST_ACTIVE)
          begin
            // retrigger ignored, interval not extended
            if (count_r == 32'h0)
            begin
              state_r <= ST_IDLE;
              o_load_switch <= 1'b0;
            end
            else
              count_r <= count_r - 32'h1;
          end
          else
          begin
            state_r <= ST_IDLE;
            o_load_switch <= 1'b0;
            if (closure)
            begin
              state_r <= ST_ACTIVE;
              count_r <= span_m1;
              o_load_switch <= 1'b1;
            end
          end
        end
        MODE_ON_OFF:
        begin
          if (!ctl_sync_r)
          begin
            state_r <= ST_IDLE;
            o_load_switch <= 1'b0;
          end
          else
          begin
            case (state_r)
              ST_IDLE:
              begin
                state_r <= ST_DELAY;
                count_r <= span_m1;
                o_load_switch <= 1'b0;
              end
              ST_DELAY:
              begin
                if (count_r == 32'h0)
                begin
                  state_r <= ST_ACTIVE;
                  o_load_switch <= 1'b1;
                end
                else
                  count_r <= count_r - 32'h1;
              end
              default:
                o_load_switch <= 1'b1;
            endcase
          end
        end
        default:
        begin
          // memory latch
          state_r <= ST_IDLE;
          if (closure)
            o_load_switch <= !o_load_switch;
        end
      endcase
    end
  end

  property p_rest_when_unpowered;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      !i_power_valid |=> !o_load_switch;
  endproperty
  a_rest_when_unpowered: assert property (p_rest_when_unpowered)
    else $error("load on after power loss");

  property p_latch_toggle;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_LATCH && i_power_valid && closure) |=>
        (o_load_switch != $past(o_load_switch));
  endproperty
  a_latch_toggle: assert property (p_latch_toggle)
    else $error("latch did not toggle");

  property p_one_shot_fire;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ONE_SHOT && i_power_valid && closure && !o_load_switch)
        |=> o_load_switch;
  endproperty
  a_one_shot_fire: assert property (p_one_shot_fire)
    else $error("one shot did not fire");

  property p_on_off_open;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ON_OFF && !ctl_sync_r) |=> !o_load_switch;
  endproperty
  a_on_off_open: assert property (p_on_off_open)
    else $error("on/off load on with control open");

  property p_on_off_start_rest;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ON_OFF && i_power_valid && closure && state_r == ST_IDLE)
        |=> !o_load_switch;
  endproperty
  a_on_off_start_rest: assert property (p_on_off_start_rest)
    else $error("on/off load on at closure");

  property p_single_edge;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      closure |=> !closure;
  endproperty
  a_single_edge: assert property (p_single_edge)
    else $error("closure event longer than one cycle");

  property p_pulse_no_repeat;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_PULSE_GEN && state_r == ST_DONE && i_power_valid)
        |=> !o_load_switch;
  endproperty
  a_pulse_no_repeat: assert property (p_pulse_no_repeat)
    else $error("second pulse without power cycle");

  property p_one_shot_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ONE_SHOT && state_r == ST_ACTIVE && count_r != 32'h0
        && i_power_valid) |=> (o_load_switch && count_r == $past(count_r) - 32'h1);
  endproperty
  a_one_shot_hold: assert property (p_one_shot_hold)
    else $error("one shot interval disturbed");

  // pulse mode: a power-up edge arms the delay with the load still at rest
  property p_pulse_arm;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_PULSE_GEN && pv_rise && state_r == ST_IDLE)
        |=> (!o_load_switch && state_r == ST_DELAY);
  endproperty
  a_pulse_arm: assert property (p_pulse_arm)
    else $error("pulse delay not armed at power up");

  // pulse mode: delay expiry starts the output pulse
  property p_pulse_start;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_PULSE_GEN && i_power_valid && state_r == ST_DELAY && count_r == 32'h0)
        |=> (o_load_switch && state_r == ST_ACTIVE);
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("pulse did not start after delay");

  // pulse mode: pulse ends once its width has run out
  property p_pulse_end;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_PULSE_GEN && i_power_valid && state_r == ST_ACTIVE && count_r == 32'h0)
        |=> (!o_load_switch && state_r == ST_DONE);
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse did not end after its width");

  // pulse mode: without a power-up edge nothing, closures included, leaves idle
  property p_pulse_idle_quiet;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_PULSE_GEN && i_power_valid && !pv_rise && state_r == ST_IDLE)
        |=> (state_r == ST_IDLE);
  endproperty
  a_pulse_idle_quiet: assert property (p_pulse_idle_quiet)
    else $error("pulse mode left idle without power up");

  // one shot: expiry drops the load and rearms
  property p_one_shot_expire;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ONE_SHOT && i_power_valid && state_r == ST_ACTIVE && count_r == 32'h0)
        |=> (!o_load_switch && state_r == ST_IDLE);
  endproperty
  a_one_shot_expire: assert property (p_one_shot_expire)
    else $error("one shot did not release at expiry");

  // one shot: armed and waiting, the load stays at rest
  property p_one_shot_idle;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ONE_SHOT && i_power_valid && state_r == ST_IDLE && !closure)
        |=> (!o_load_switch && state_r == ST_IDLE);
  endproperty
  a_one_shot_idle: assert property (p_one_shot_idle)
    else $error("one shot left rest without trigger");

  // on/off: expiry with control still closed turns the load on
  property p_on_off_expire;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ON_OFF && i_power_valid && ctl_sync_r && state_r == ST_DELAY
        && count_r == 32'h0) |=> o_load_switch;
  endproperty
  a_on_off_expire: assert property (p_on_off_expire)
    else $error("on/off load not on after delay");

  // on/off: load stays on while control stays closed
  property p_on_off_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_ON_OFF && i_power_valid && ctl_sync_r && o_load_switch)
        |=> o_load_switch;
  endproperty
  a_on_off_hold: assert property (p_on_off_hold)
    else $error("on/off load dropped with control closed");

  // latch: without a closure the latched state does not move
  property p_latch_hold;
    @(posedge i_ref_clk) disable iff (!i_rstn)
      (i_mode == MODE_LATCH && i_power_valid && !closure)
        |=> (o_load_switch == $past(o_load_switch));
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch changed without closure");
endmodule : multi_mode_delay_timer

// ---- tb/control_switch_model.sv ----
// dry contact control switch that drives the timer's control input
module control_switch_model (
  input wire logic i_close,
  output logic o_contact
);
  timeunit 1ns;
  timeprecision 1ps;
  // clean contact, no bounce; the bench opens it between closures
  assign o_contact = i_close;
endmodule : control_switch_model

// ---- tb/multi_mode_delay_timer_tb_top.sv ----
// self-checking bench for the multi mode delay timer
module multi_mode_delay_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import delay_timer_pkg::*;
  localparam int P = 20;
  localparam int CAP = 60;
  logic clk, rstn, pv, sw, ctl, o;
  mode_t mode;
  logic [31:0] dly;
  int fail_count = 0;
  int n_checks = 0;
  typedef struct {mode_t m; int d, h, re, llo, lhi, wlo, whi;} row_t;
  // mode, delay, hold, reclose, latency range, width range
  row_t rows[5] = '{
    '{MODE_PULSE_GEN, 5, 30, 0, 6, 6, P, P},
    '{MODE_ONE_SHOT, 8, 2, 6, 3, 3, 8, 8},
    '{MODE_ONE_SHOT, 1, 2, 0, 3, 3, 1, 1},
    '{MODE_ON_OFF, 6, 30, 0, 8, 11, 20, 27},
    '{MODE_ON_OFF, 10, 3, 0, CAP, CAP, 0, 0}
  };
  control_switch_model control_switch_model_inst (.i_close(sw), .o_contact(ctl));
  // short pulse width keeps the run brief
  multi_mode_delay_timer #(.PULSE_CYCLES(32'h0000_0014)) multi_mode_delay_timer_inst (
    .i_ref_clk(clk), .i_rstn(rstn), .i_power_valid(pv), .i_control_input(ctl),
    .i_mode(mode), .i_delay_span(dly), .o_load_switch(o));
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task automatic chk_bit(input logic exp);
    n_checks++;
    if (o !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, o, exp);
    end
  endtask : chk_bit
  task automatic pwr(input logic v, input int n);
    pv = v;
    repeat (n) @(negedge clk);
  endtask : pwr
  task automatic tap();
    sw = 1'b1;
    repeat (3) @(negedge clk);
    sw = 1'b0;
    repeat (3) @(negedge clk);
  endtask : tap
  // closure pattern in parallel with latency and width measurement
  task automatic run(input int h, input int re, output int lat, output int wid);
    lat = 0;
    wid = 0;
    fork
      begin
        sw = 1'b1;
        repeat (h) @(negedge clk);
        sw = 1'b0;
        if (re > 0)
        begin
          repeat (re - h) @(negedge clk);
          sw = 1'b1;
          repeat (2) @(negedge clk);
          sw = 1'b0;
        end
      end
      begin
        while (o !== 1'b1 && lat < CAP)
        begin
          @(negedge clk);
          lat++;
        end
        while (o === 1'b1 && wid < CAP)
        begin
          @(negedge clk);
          wid++;
        end
      end
    join
  endtask : run
  // free running reference clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog, about twenty-five times the expected run
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end
  // main sequence: table rows, then hand-written cases
  initial
  begin
    int lat;
    int wid;
    rstn = 1'b0;
    pv = 1'b0;
    sw = 1'b0;
    mode = MODE_PULSE_GEN;
    dly = 32'h0000_0005;
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    chk_bit(1'b0);
    $display("test reset done");
    foreach (rows[i])
    begin
      pwr(1'b0, 3);
      mode = rows[i].m;
      dly = 32'(rows[i].d);
      if (rows[i].m != MODE_PULSE_GEN)
        pwr(1'b1, 3);
      pv = 1'b1;
      run(rows[i].h, rows[i].re, lat, wid);
      chk_rng(lat, rows[i].llo, rows[i].lhi);
      chk_rng(wid, rows[i].wlo, rows[i].whi);
      $display("test row %0d done", i);
    end
    pwr(1'b0, 3);
    mode = MODE_PULSE_GEN;
    dly = 32'h0000_0003;
    pv = 1'b1;
    run(2, 0, lat, wid);
    chk_rng(wid, P, P);
    run(2, 0, lat, wid);
    chk_rng(lat, CAP, CAP);
    $display("test pulse once done");
    pwr(1'b0, 3);
    mode = MODE_ONE_SHOT;
    dly = 32'h0000_0004;
    run(2, 0, lat, wid);
    chk_rng(lat, CAP, CAP);
    pwr(1'b1, 3);
    run(2, 0, lat, wid);
    run(2, 0, lat, wid);
    chk_rng(lat, 3, 3);
    chk_rng(wid, 4, 4);
    $display("test one shot rearm done");
    pwr(1'b0, 2);
    mode = MODE_ON_OFF;
    pwr(1'b1, 2);
    sw = 1'b1;
    repeat (15) @(negedge clk);
    chk_bit(1'b1);
    pwr(1'b0, 1);
    chk_bit(1'b0);
    pwr(1'b1, 3);
    chk_bit(1'b0);
    sw = 1'b0;
    $display("test on off power loss done");
    pwr(1'b0, 2);
    mode = MODE_LATCH;
    pwr(1'b1, 2);
    sw = 1'b1;
    repeat (10) @(negedge clk);
    chk_bit(1'b1);
    sw = 1'b0;
    repeat (3) @(negedge clk);
    tap();
    chk_bit(1'b0);
    tap();
    chk_bit(1'b1);
    pwr(1'b0, 1);
    chk_bit(1'b0);
    pwr(1'b1, 3);
    chk_bit(1'b0);
    $display("test latch done");
    print_verdict();
  end
endmodule : multi_mode_delay_timer_tb_top
